// [can_irq_pkg.sv]
// package: register map, field layout and event carriers of the CAN interrupt source block
package can_irq_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] OFS_RX_CFG     = 8'h00;
	localparam logic [7:0] OFS_RX_TIMING  = 8'h04;
	localparam logic [7:0] OFS_RX_FLAGS   = 8'h08;
	localparam logic [7:0] OFS_GERR_EN    = 8'h0c;
	localparam logic [7:0] OFS_GERR_FLAGS = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h24;
	localparam logic [7:0] OFS_CH_BASE    = 8'h40;
	localparam logic [7:0] CH_STRIDE      = 8'h10;
	localparam logic [3:0] OFS_CH_EN      = 4'h0;
	localparam logic [3:0] OFS_CH_MODE    = 4'h4;
	localparam logic [3:0] OFS_CH_FLAGS   = 4'h8;

	// sizes
	localparam int MAX_RX_FIFO  = 8;
	localparam int TXBUF_PER_CH = 4;
	localparam int TXQ_PER_CH   = 2;
	localparam int TRX_PER_CH   = 2;
	localparam int LVL_W        = 8;
	localparam int TIMING_W     = 3;
	localparam int GERR_N       = 7;
	localparam int CH_W         = 16;
	localparam int MODE_W       = 5;
	localparam int IRQ_N        = 5;

	// rx config fields
	localparam int RX_EN_LSB   = 0;
	localparam int RX_FULL_LSB = 8;
	localparam int RX_MODE_LSB = 16;

	// global error bits, enable and flag share the layout
	localparam int GE_LEN       = 0;
	localparam int GE_FIFO_LOST = 1;
	localparam int GE_HIST_OVF  = 2;
	localparam int GE_PAYLOAD   = 3;
	localparam int GE_Q_OVW     = 4;
	localparam int GE_Q_LOST    = 5;
	localparam int GE_FIFO_OVW  = 6;
	localparam int GW_MODE_BIT  = 8;

	// channel enable and flag layout (flag bit 4 reads zero)
	localparam int CH_BUF_LSB   = 0;
	localparam int CH_ABORT_BIT = 4;
	localparam int CH_TXQ_LSB   = 5;
	localparam int CH_TXQF_LSB  = 7;
	localparam int CH_HIST_BIT  = 9;
	localparam int CH_TRX_LSB   = 10;
	localparam int CH_TRXF_LSB  = 12;
	localparam int CH_TRXRX_BIT = 14;
	localparam int CH_ERR_BIT   = 15;

	// channel mode layout: 1 = every message, 0 = on empty / level
	localparam int MD_TXQ_LSB  = 0;
	localparam int MD_HIST_BIT = 2;
	localparam int MD_TRX_LSB  = 3;

	// summary status bits
	localparam int IRQ_RXF   = 0;
	localparam int IRQ_GERR  = 1;
	localparam int IRQ_TX    = 2;
	localparam int IRQ_TRXRX = 3;
	localparam int IRQ_CHERR = 4;

	localparam logic [31:0] RST_ZERO = 32'h0;

	typedef struct packed {
		logic             stored;
		logic             full;
		logic [LVL_W-1:0] level;
	} rx_evt_type;

	typedef struct packed {
		logic len_check_err;
		logic fifo_lost;
		logic history_ovf;
		logic payload_ovf;
		logic queue_overwrite;
		logic queue_lost;
		logic fifo_overwrite;
	} gerr_evt_type;

	typedef struct packed {
		logic [TXBUF_PER_CH-1:0] buf_done;
		logic [TXBUF_PER_CH-1:0] buf_abort;
		logic [TXQ_PER_CH-1:0]   txq_empty;
		logic [TXQ_PER_CH-1:0]   txq_msg;
		logic [TXQ_PER_CH-1:0]   txq_frame;
		logic                    hist_store;
		logic [LVL_W-1:0]        hist_level;
		logic [TRX_PER_CH-1:0]   trx_empty;
		logic [TRX_PER_CH-1:0]   trx_msg;
		logic [TRX_PER_CH-1:0]   trx_frame;
		logic                    trx_rx;
		logic                    ch_err;
	} ch_evt_type;

endpackage

// [can_irq_sources.sv]
// can interrupt source flags, enables and the five request outputs
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
module can_irq_sources #(
	parameter int NUM_RX_FIFO = 8,
	parameter int NUM_CH      = 2,
	parameter int RX_DEPTH    = 16,
	parameter int HIST_DEPTH  = 32
) (
	input  wire logic                                   clk_sys,
	input  wire logic                                   rst_n,
	input  wire logic                                   ce,
	input  wire logic [can_irq_pkg::ADDR_W-1:0]         addr,
	input  wire logic [can_irq_pkg::DATA_W-1:0]         wdata,
	input  wire logic                                   wr,
	input  wire logic                                   rd,
	output      logic [can_irq_pkg::DATA_W-1:0]         rdata,
	input  wire can_irq_pkg::rx_evt_type [NUM_RX_FIFO-1:0] rx_evt,
	input  wire can_irq_pkg::gerr_evt_type              gerr_evt,
	input  wire can_irq_pkg::ch_evt_type [NUM_CH-1:0]   ch_evt,
	output      logic                                   irq_rx_fifo,
	output      logic                                   irq_global_err,
	output      logic [NUM_CH-1:0]                      irq_tx,
	output      logic [NUM_CH-1:0]                      irq_trx_rx,
	output      logic [NUM_CH-1:0]                      irq_ch_err,
	output      logic                                   irq
);

	localparam int HIST_3Q = (HIST_DEPTH * 3) / 4;

	logic [31:0]                              rx_cfg_r;
	logic [NUM_RX_FIFO*can_irq_pkg::TIMING_W-1:0] rx_timing_r;
	logic [NUM_RX_FIFO-1:0]                   rx_irq_flag_r;
	logic [NUM_RX_FIFO-1:0]                   rx_full_flag_r;
	logic [NUM_RX_FIFO-1:0]                   rx_full_d_r;
	logic [NUM_RX_FIFO-1:0]                   rx_irq_set;
	logic [NUM_RX_FIFO-1:0]                   rx_full_set;
	logic [8:0]                               gerr_en_r;
	logic [can_irq_pkg::GERR_N-1:0]           gerr_flag_r;
	logic [can_irq_pkg::GERR_N-1:0]           gerr_set;
	logic [can_irq_pkg::IRQ_N-1:0]            irq_status_r;
	logic [can_irq_pkg::IRQ_N-1:0]            irq_mask_r;
	logic [can_irq_pkg::IRQ_N-1:0]            cls_prev_r;
	logic [can_irq_pkg::IRQ_N-1:0]            cls;
	logic [can_irq_pkg::DATA_W-1:0]           rdata_r;
	logic [can_irq_pkg::DATA_W-1:0]           rdata_nxt;
	wire  [NUM_CH-1:0][can_irq_pkg::CH_W-1:0]   ch_en_w;
	wire  [NUM_CH-1:0][can_irq_pkg::MODE_W-1:0] ch_mode_w;
	wire  [NUM_CH-1:0][can_irq_pkg::CH_W-1:0]   ch_flag_w;
	logic                                     wr_go;
	logic                                     rd_go;

	assign wr_go = wr & ce;
	assign rd_go = rd & ce;

	// receive fifo sources
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_cfg_r    <= can_irq_pkg::RST_ZERO;
			rx_timing_r <= '0;
		end
		else if (wr_go && addr == can_irq_pkg::OFS_RX_CFG)
			rx_cfg_r <= {8'h00, wdata[23:0]};
		else if (wr_go && addr == can_irq_pkg::OFS_RX_TIMING)
			rx_timing_r <= wdata[NUM_RX_FIFO*can_irq_pkg::TIMING_W-1:0];
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_RX_FIFO; gi++)
		begin : g_rx
			logic [2:0] tsel;
			logic [9:0] thr;
			assign tsel = rx_timing_r[gi*can_irq_pkg::TIMING_W +: can_irq_pkg::TIMING_W];
			// threshold is (timing+1)/8 of the fifo depth
			assign thr = 10'((RX_DEPTH * (int'(tsel) + 1)) / 8);
			assign rx_irq_set[gi] = rx_evt[gi].stored &
				(rx_cfg_r[can_irq_pkg::RX_MODE_LSB+gi] | ({2'b00, rx_evt[gi].level} >= thr));
			assign rx_full_set[gi] = rx_evt[gi].full & ~rx_full_d_r[gi];
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_irq_flag_r  <= '0;
			rx_full_flag_r <= '0;
			rx_full_d_r    <= '0;
		end
		else if (ce)
		begin
			// last full level per fifo, so a full flag sets only on the rising level
			rx_full_d_r <= rx_full_level();
			// set wins over a same-cycle write-one-to-clear
			rx_irq_flag_r  <= (rx_irq_flag_r & ~((wr_go && addr == can_irq_pkg::OFS_RX_FLAGS) ?
				wdata[NUM_RX_FIFO-1:0] : '0)) | rx_irq_set;
			rx_full_flag_r <= (rx_full_flag_r & ~((wr_go && addr == can_irq_pkg::OFS_RX_FLAGS) ?
				wdata[can_irq_pkg::RX_FULL_LSB +: NUM_RX_FIFO] : '0)) | rx_full_set;
		end
	end

	function automatic logic [NUM_RX_FIFO-1:0] rx_full_level();
		logic [NUM_RX_FIFO-1:0] v;
		v = '0;
		for (int i = 0; i < NUM_RX_FIFO; i++)
			v[i] = rx_evt[i].full;
		return v;
	endfunction

	assign irq_rx_fifo = |(rx_irq_flag_r & rx_cfg_r[can_irq_pkg::RX_EN_LSB +: NUM_RX_FIFO]) |
		|(rx_full_flag_r & rx_cfg_r[can_irq_pkg::RX_FULL_LSB +: NUM_RX_FIFO]);

	// global error sources
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			gerr_en_r <= '0;
		else if (wr_go && addr == can_irq_pkg::OFS_GERR_EN)
			gerr_en_r <= wdata[8:0];
	end

	// overwrite in the trx fifo only counts while gateway mode is on
	assign gerr_set = {gerr_evt.fifo_overwrite & gerr_en_r[can_irq_pkg::GW_MODE_BIT],
		gerr_evt.queue_lost, gerr_evt.queue_overwrite, gerr_evt.payload_ovf,
		gerr_evt.history_ovf, gerr_evt.fifo_lost, gerr_evt.len_check_err};

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			gerr_flag_r <= '0;
		else if (ce)
			gerr_flag_r <= (gerr_flag_r & ~((wr_go && addr == can_irq_pkg::OFS_GERR_FLAGS) ?
				wdata[can_irq_pkg::GERR_N-1:0] : '0)) | gerr_set;
	end

	assign irq_global_err = |(gerr_flag_r & gerr_en_r[can_irq_pkg::GERR_N-1:0]);

	// channel sources
	genvar gc;
	generate
		for (gc = 0; gc < NUM_CH; gc++)
		begin : g_ch
			localparam logic [7:0] CB = 8'(can_irq_pkg::OFS_CH_BASE + gc * can_irq_pkg::CH_STRIDE);
			logic                               sel;
			logic [can_irq_pkg::CH_W-1:0]       en_r;
			logic [can_irq_pkg::MODE_W-1:0]     mode_r;
			logic [can_irq_pkg::CH_W-1:0]       flag_r;
			logic [can_irq_pkg::CH_W-1:0]       set;
			logic [can_irq_pkg::CH_W-1:0]       clr;
			logic [can_irq_pkg::TXBUF_PER_CH-1:0] abort_cause_r;
			logic [can_irq_pkg::TXBUF_PER_CH-1:0] done_cause_r;
			logic [can_irq_pkg::TXBUF_PER_CH-1:0] buf_clr;
			can_irq_pkg::ch_evt_type            ev;

			assign ev  = ch_evt[gc];
			assign sel = addr[7:4] == CB[7:4];
			assign clr = (wr_go && sel && addr[3:0] == can_irq_pkg::OFS_CH_FLAGS) ? wdata[15:0] : '0;
			assign buf_clr = clr[can_irq_pkg::CH_BUF_LSB +: can_irq_pkg::TXBUF_PER_CH];

			always_ff @(posedge clk_sys or negedge rst_n)
			begin
				if (!rst_n)
				begin
					en_r   <= '0;
					mode_r <= '0;
				end
				else if (wr_go && sel && addr[3:0] == can_irq_pkg::OFS_CH_EN)
					en_r <= wdata[15:0];
				else if (wr_go && sel && addr[3:0] == can_irq_pkg::OFS_CH_MODE)
					mode_r <= wdata[can_irq_pkg::MODE_W-1:0];
			end

			always_comb
			begin
				set = '0;
				set[can_irq_pkg::CH_BUF_LSB +: 4] = ev.buf_done | ev.buf_abort;
				set[can_irq_pkg::CH_TXQ_LSB +: 2] = ev.txq_msg & mode_r[can_irq_pkg::MD_TXQ_LSB +: 2] |
					ev.txq_empty & ~mode_r[can_irq_pkg::MD_TXQ_LSB +: 2];
				set[can_irq_pkg::CH_TXQF_LSB +: 2] = ev.txq_frame;
				set[can_irq_pkg::CH_HIST_BIT] = ev.hist_store &
					(mode_r[can_irq_pkg::MD_HIST_BIT] | (int'(ev.hist_level) >= HIST_3Q));
				set[can_irq_pkg::CH_TRX_LSB +: 2] = ev.trx_msg & mode_r[can_irq_pkg::MD_TRX_LSB +: 2] |
					ev.trx_empty & ~mode_r[can_irq_pkg::MD_TRX_LSB +: 2];
				set[can_irq_pkg::CH_TRXF_LSB +: 2] = ev.trx_frame;
				set[can_irq_pkg::CH_TRXRX_BIT] = ev.trx_rx;
				set[can_irq_pkg::CH_ERR_BIT]   = ev.ch_err;
			end

			always_ff @(posedge clk_sys or negedge rst_n)
			begin
				if (!rst_n)
					flag_r <= '0;
				else if (ce)
					flag_r <= ((flag_r & ~clr) | set) & ~(16'h0001 << can_irq_pkg::CH_ABORT_BIT);
			end

			// remember why a result flag is up so each cause is gated by its own enable
			always_ff @(posedge clk_sys or negedge rst_n)
			begin
				if (!rst_n)
				begin
					done_cause_r  <= '0;
					abort_cause_r <= '0;
				end
				else if (ce)
				begin
					done_cause_r  <= (done_cause_r & ~buf_clr) | ev.buf_done;
					abort_cause_r <= (abort_cause_r & ~buf_clr) | ev.buf_abort;
				end
			end

			assign irq_tx[gc] =
				|(flag_r[3:0] & done_cause_r & en_r[can_irq_pkg::CH_BUF_LSB +: 4]) |
				|(flag_r[3:0] & abort_cause_r & {4{en_r[can_irq_pkg::CH_ABORT_BIT]}}) |
				|(flag_r[13:5] & en_r[13:5]);
			assign irq_trx_rx[gc] = flag_r[can_irq_pkg::CH_TRXRX_BIT] & en_r[can_irq_pkg::CH_TRXRX_BIT];
			assign irq_ch_err[gc] = flag_r[can_irq_pkg::CH_ERR_BIT] & en_r[can_irq_pkg::CH_ERR_BIT];

			assign ch_en_w[gc]   = en_r;
			assign ch_mode_w[gc] = mode_r;
			assign ch_flag_w[gc] = flag_r;
		end
	endgenerate

	// summary status: rising request of any class is latched
	assign cls = {|irq_ch_err, |irq_trx_rx, |irq_tx, irq_global_err, irq_rx_fifo};

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cls_prev_r   <= '0;
			irq_status_r <= '0;
		end
		else if (ce)
		begin
			cls_prev_r   <= cls;
			irq_status_r <= (irq_status_r & ~((wr_go && addr == can_irq_pkg::OFS_IRQ_STATUS) ?
				wdata[can_irq_pkg::IRQ_N-1:0] : '0)) | (cls & ~cls_prev_r);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			irq_mask_r <= '0;
		else if (wr_go && addr == can_irq_pkg::OFS_IRQ_MASK)
			irq_mask_r <= wdata[can_irq_pkg::IRQ_N-1:0];
	end

	assign irq = |(irq_status_r & irq_mask_r);

	// read port, data valid only in the cycle after the strobe
	always_comb
	begin
		rdata_nxt = '0;
		case (addr)
			can_irq_pkg::OFS_RX_CFG:     rdata_nxt = rx_cfg_r;
			can_irq_pkg::OFS_RX_TIMING:  rdata_nxt[NUM_RX_FIFO*3-1:0] = rx_timing_r;
			can_irq_pkg::OFS_RX_FLAGS:   rdata_nxt = 32'({rx_full_flag_r, 8'h00} | 16'(rx_irq_flag_r));
			can_irq_pkg::OFS_GERR_EN:    rdata_nxt[8:0] = gerr_en_r;
			can_irq_pkg::OFS_GERR_FLAGS: rdata_nxt[can_irq_pkg::GERR_N-1:0] = gerr_flag_r;
			can_irq_pkg::OFS_IRQ_STATUS: rdata_nxt[can_irq_pkg::IRQ_N-1:0] = irq_status_r;
			can_irq_pkg::OFS_IRQ_MASK:   rdata_nxt[can_irq_pkg::IRQ_N-1:0] = irq_mask_r;
			default:
			begin
				for (int c = 0; c < NUM_CH; c++)
				begin
					if (addr[7:4] == 4'(c + 4))
					begin
						if (addr[3:0] == can_irq_pkg::OFS_CH_EN)
							rdata_nxt[15:0] = ch_en_w[c];
						else if (addr[3:0] == can_irq_pkg::OFS_CH_MODE)
							rdata_nxt[can_irq_pkg::MODE_W-1:0] = ch_mode_w[c];
						else if (addr[3:0] == can_irq_pkg::OFS_CH_FLAGS)
							rdata_nxt[15:0] = ch_flag_w[c];
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			rdata_r <= '0;
		else if (ce)
			rdata_r <= rd_go ? rdata_nxt : '0;
	end

	assign rdata = rdata_r;

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_rx_every_msg: assert property (ce && rx_evt[0].stored && rx_cfg_r[can_irq_pkg::RX_MODE_LSB]
		|=> rx_irq_flag_r[0]) else $error("rx fifo flag not set on message");
	a_rx_full_edge: assert property (ce && rx_evt[0].full && !rx_full_d_r[0]
		|=> rx_full_flag_r[0]) else $error("rx full flag not set");
	a_len_err_irq: assert property (ce && gerr_evt.len_check_err && gerr_en_r[can_irq_pkg::GE_LEN]
		|=> irq_global_err) else $error("length error did not request");
	a_lost_irq: assert property (ce && gerr_evt.fifo_lost && gerr_en_r[can_irq_pkg::GE_FIFO_LOST]
		|=> irq_global_err) else $error("fifo lost did not request");
	a_hist_ovf_flag: assert property (ce && gerr_evt.history_ovf
		|=> gerr_flag_r[can_irq_pkg::GE_HIST_OVF]) else $error("history overflow not flagged");
	a_payload_irq: assert property (ce && gerr_evt.payload_ovf && gerr_en_r[can_irq_pkg::GE_PAYLOAD]
		##1 1 |-> irq_global_err) else $error("payload overflow did not request");
	a_qovw_flag: assert property (ce && gerr_evt.queue_overwrite
		|=> gerr_flag_r[can_irq_pkg::GE_Q_OVW]) else $error("queue overwrite not flagged");
	a_qlost_flag: assert property (ce && gerr_evt.queue_lost
		|=> gerr_flag_r[can_irq_pkg::GE_Q_LOST]) else $error("queue lost not flagged");
	a_ovw_gw_only: assert property (ce && !gerr_en_r[can_irq_pkg::GW_MODE_BIT]
		&& !gerr_flag_r[can_irq_pkg::GE_FIFO_OVW] |=> !gerr_flag_r[can_irq_pkg::GE_FIFO_OVW])
		else $error("fifo overwrite flagged outside gateway mode");
	a_buf_done_irq: assert property (ce && ch_evt[0].buf_done[0] && ch_en_w[0][0]
		|=> irq_tx[0]) else $error("buffer completion did not request");
	a_abort_irq: assert property (ce && ch_evt[0].buf_abort[0] && ch_en_w[0][can_irq_pkg::CH_ABORT_BIT]
		|=> irq_tx[0]) else $error("abort completion did not request");
	a_txq_msg_flag: assert property (ce && ch_evt[0].txq_msg[0] && ch_mode_w[0][can_irq_pkg::MD_TXQ_LSB]
		|=> ch_flag_w[0][can_irq_pkg::CH_TXQ_LSB]) else $error("queue flag not set");
	a_hist_3q_flag: assert property (ce && ch_evt[0].hist_store && int'(ch_evt[0].hist_level) >= HIST_3Q
		|=> ch_flag_w[0][can_irq_pkg::CH_HIST_BIT]) else $error("history flag not set");
	a_trx_empty_flag: assert property (ce && ch_evt[0].trx_empty[0] && !ch_mode_w[0][can_irq_pkg::MD_TRX_LSB]
		|=> ch_flag_w[0][can_irq_pkg::CH_TRX_LSB]) else $error("trx tx flag not set");
	a_trx_frame_irq: assert property (ce && ch_evt[0].trx_frame[0] && ch_en_w[0][can_irq_pkg::CH_TRXF_LSB]
		|=> irq_tx[0]) else $error("trx frame did not request");
	a_txq_frame_irq: assert property (ce && ch_evt[0].txq_frame[0] && ch_en_w[0][can_irq_pkg::CH_TXQF_LSB]
		|=> irq_tx[0]) else $error("queue frame did not request");
	a_flag_sticky: assert property (gerr_flag_r[can_irq_pkg::GE_LEN]
		&& !(wr && addr == can_irq_pkg::OFS_GERR_FLAGS && wdata[can_irq_pkg::GE_LEN])
		|=> gerr_flag_r[can_irq_pkg::GE_LEN]) else $error("flag dropped without clear");

	c_global_err: cover property (gerr_evt.len_check_err ##1 irq_global_err);
	c_tx_irq: cover property (ch_evt[0].buf_done[0] ##1 irq_tx[0]);
	c_summary: cover property (irq ##[1:20] !irq);

endmodule

// [ext_irq_ctrl_model.sv]
// model of the level-sensitive external interrupt controller fed by the five request outputs
`timescale 1ns/100ps
module ext_irq_ctrl_model (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic [4:0] src,
	input  wire logic [4:0] en,
	output      logic [4:0] req
);
	// level sensitive: a request follows its source while enabled, with one flop of delay
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			req <= 5'h00;
		else
			req <= src & en;
	end
endmodule

// [can_irq_sources_tb_top.sv]
// self-checking testbench of the can interrupt source block
`timescale 1ns/100ps
module can_irq_sources_tb_top;
	localparam logic [7:0] GE = can_irq_pkg::OFS_GERR_EN;
	localparam logic [7:0] GF = can_irq_pkg::OFS_GERR_FLAGS;
	localparam logic [7:0] RC = can_irq_pkg::OFS_RX_CFG;
	localparam logic [7:0] RF = can_irq_pkg::OFS_RX_FLAGS;
	logic                          clk_sys = 1'b0;
	logic                          rst_n = 1'b0;
	logic                          ce = 1'b1;
	logic [7:0]                    addr = 8'h00;
	logic [31:0]                   wdata = 32'h0;
	logic                          wr = 1'b0;
	logic                          rd = 1'b0;
	logic [31:0]                   rdata;
	can_irq_pkg::rx_evt_type [7:0] rx_evt = '0;
	can_irq_pkg::gerr_evt_type     gerr_evt = '0;
	can_irq_pkg::ch_evt_type [1:0] ch_evt = '0;
	logic                          irq_rx_fifo;
	logic                          irq_global_err;
	logic                          irq;
	logic [1:0]                    irq_tx;
	logic [1:0]                    irq_trx_rx;
	logic [1:0]                    irq_ch_err;
	logic [4:0]                    ext_en = 5'h1f;
	logic [4:0]                    ext_req;
	logic [15:0]                   rnd = 16'h0051;
	logic [31:0]                   v;
	int                            error_cnt = 0;
	int                            check_count = 0;
	int                            cs = 0;

	always #25 clk_sys = ~clk_sys;

	can_irq_sources #(.NUM_RX_FIFO(8), .NUM_CH(2), .RX_DEPTH(16), .HIST_DEPTH(32)) dut_u (
		.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .rx_evt(rx_evt), .gerr_evt(gerr_evt), .ch_evt(ch_evt), .irq_rx_fifo(irq_rx_fifo),
		.irq_global_err(irq_global_err), .irq_tx(irq_tx), .irq_trx_rx(irq_trx_rx), .irq_ch_err(irq_ch_err), .irq(irq));

	ext_irq_ctrl_model irq_ctl_u (.clk_sys(clk_sys), .rst_n(rst_n), .en(ext_en), .req(ext_req),
		.src({|irq_ch_err, |irq_trx_rx, |irq_tx, irq_global_err, irq_rx_fifo}));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic int rx_thr(input int t);
		return 16 * (t + 1) / 8;
	endfunction

	function automatic logic [7:0] cha(input int o);
		return 8'(int'(can_irq_pkg::OFS_CH_BASE) + int'(can_irq_pkg::CH_STRIDE) * cs + o);
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		if (error_cnt == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys) {addr, wdata, wr} <= {a, d, 1'b1};
		@(posedge clk_sys) wr <= 1'b0;
		// let the write settle so a following compare sees the cleared state
		#1;
	endtask

	// read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys) {addr, rd} <= {a, 1'b1};
		@(posedge clk_sys) rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic flags_check(input logic [7:0] a, input logic [31:0] e);
		bus_rd(a, v);
		check(v, e);
		bus_wr(a, 32'hffffffff);
	endtask

	task automatic gerr_fire(input int i);
		@(posedge clk_sys) gerr_evt <= can_irq_pkg::gerr_evt_type'(7'h40 >> i);
		@(posedge clk_sys) gerr_evt <= '0;
		#1;
	endtask

	task automatic rx_fire(input int f, input int lvl, input logic st, input logic fl);
		@(posedge clk_sys) rx_evt[f] <= '{stored: st, full: fl, level: 8'(lvl)};
		@(posedge clk_sys) rx_evt[f].stored <= 1'b0;
		#1;
	endtask

	task automatic ch_step(input int k, input int i, input logic [31:0] fe, input logic [2:0] ie);
		can_irq_pkg::ch_evt_type e;
		e = '0;
		case (k)
			0: e.buf_done[i] = 1'b1;
			1: e.buf_abort[i] = 1'b1;
			2: e.txq_empty[i] = 1'b1;
			3: e.txq_msg[i] = 1'b1;
			4: e.txq_frame[i] = 1'b1;
			5: e = '{hist_store: 1'b1, hist_level: 8'(i), default: '0};
			6: e.trx_empty[i] = 1'b1;
			7: e.trx_msg[i] = 1'b1;
			8: e.trx_frame[i] = 1'b1;
			9: e.trx_rx = 1'b1;
			default: e.ch_err = 1'b1;
		endcase
		@(posedge clk_sys) ch_evt[cs] <= e;
		@(posedge clk_sys) ch_evt[cs] <= '0;
		#1;
		check(32'({irq_ch_err[cs], irq_trx_rx[cs], irq_tx[cs]}), 32'(ie));
		flags_check(cha(8), fe);
		check(32'({irq_ch_err[cs], irq_trx_rx[cs], irq_tx[cs]}), 32'h0);
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		tally_and_finish();
	end

	initial
	begin
		int f;
		int t;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		bus_wr(8'h30, 32'hffffffff);
		bus_rd(8'h30, v);
		check(v, 32'h0);
		check(32'({irq, irq_global_err, irq_rx_fifo, irq_tx}), 32'h0);
		// a strobe while the clock enable is low must leave every flag alone
		@(posedge clk_sys) ce <= 1'b0;
		gerr_fire(0);
		@(posedge clk_sys) ce <= 1'b1;
		flags_check(GF, 32'h0);
		bus_wr(can_irq_pkg::OFS_IRQ_MASK, 32'h2);
		for (int i = 0; i < 7; i++)
		begin
			ext_en <= (i == 3) ? 5'h1d : 5'h1f;
			bus_wr(GE, (32'h1 << i) | 32'h100);
			gerr_fire(i);
			check(32'(irq_global_err), 32'h1);
			@(posedge clk_sys) #1;
			check(32'(ext_req[1]), 32'(i != 3));
			check(32'(irq), 32'h1);
			bus_wr(can_irq_pkg::OFS_IRQ_STATUS, 32'h2);
			flags_check(GF, 32'h1 << i);
			check(32'({irq, irq_global_err}), 32'h0);
			bus_wr(GE, 32'h0);
			gerr_fire(i);
			check(32'(irq_global_err), 32'h0);
			flags_check(GF, (i == can_irq_pkg::GE_FIFO_OVW) ? 32'h0 : 32'h1 << i);
		end
		for (int n = 0; n < 4; n++)
		begin
			rnd = lfsr(rnd);
			f = int'(rnd[2:0]);
			t = int'(rnd[5:3]);
			bus_wr(RC, 32'h101 << f);
			bus_wr(can_irq_pkg::OFS_RX_TIMING, 32'(t) << (3 * f));
			rx_fire(f, rx_thr(t) - 1, 1'b1, 1'b0);
			check(32'(irq_rx_fifo), 32'h0);
			flags_check(RF, 32'h0);
			rx_fire(f, rx_thr(t), 1'b1, 1'b0);
			check(32'(irq_rx_fifo), 32'h1);
			flags_check(RF, 32'h1 << f);
			rx_fire(f, 16, 1'b0, 1'b1);
			check(32'(irq_rx_fifo), 32'h1);
			flags_check(RF, 32'h100 << f);
			rx_fire(f, 0, 1'b0, 1'b0);
			bus_wr(RC, 32'h10001 << f);
			rx_fire(f, 1, 1'b1, 1'b0);
			flags_check(RF, 32'h1 << f);
		end
		for (int n = 0; n < 2; n++)
		begin
			rnd = lfsr(rnd);
			cs = n;
			f = int'(rnd[1:0]);
			t = int'(rnd[2]);
			bus_wr(cha(0), 32'hffef);
			bus_wr(cha(4), 32'h0);
			ch_step(0, f, 32'h1 << f, 3'b001);
			ch_step(3, t, 32'h0, 3'b000);
			ch_step(2, t, 32'h20 << t, 3'b001);
			ch_step(4, t, 32'h80 << t, 3'b001);
			ch_step(5, 23, 32'h0, 3'b000);
			ch_step(5, 24, 32'h200, 3'b001);
			ch_step(7, t, 32'h0, 3'b000);
			ch_step(6, t, 32'h400 << t, 3'b001);
			ch_step(8, t, 32'h1000 << t, 3'b001);
			ch_step(9, 0, 32'h4000, 3'b010);
			ch_step(10, 0, 32'h8000, 3'b100);
			bus_wr(cha(4), 32'h1f);
			ch_step(3, t, 32'h20 << t, 3'b001);
			ch_step(5, 1, 32'h200, 3'b001);
			ch_step(7, t, 32'h400 << t, 3'b001);
			bus_wr(cha(0), 32'h10);
			ch_step(1, f, 32'h1 << f, 3'b001);
			ch_step(0, f, 32'h1 << f, 3'b000);
			ch_step(4, t, 32'h80 << t, 3'b000);
		end
		tally_and_finish();
	end
endmodule
